// >>> rtl/rxbc_pkg.sv
// Constants, register map and types for the receive code and channel control block.
// Assumes one 125 MHz clock and an 8-bit host register port per framer port.
// Summary of operation
// RULE1: Host sets reset request; device clears when done.
// RULE2: Filter selections apply only after controller reset.
// RULE3: Clear filter: 16/32/48/64 codeless bits.
// RULE4: Valid filter: none/3/5/7 identical codes.
// RULE5: Integration and disintegration never run together.
// RULE6: One idle code register per channel.
// RULE7: Channels 25-32 idle codes E1 only.
// RULE8: T1 masks force channel signaling to ones.
// RULE9: Signaling output keeps the real received bits.
// RULE10: Forcing only while control force bit set.
// RULE11: Milliwatt masks replace channel data with code.
// RULE12: Sixteen signaling words, channel k and k+12.
// RULE13: Eight ports, each 200h apart.
// RULE14: Control bit 4 enables per-channel forcing.
// RULE15: Signaling words freeze while out of frame.
// RULE16: Reset request reads one; clears detect state.
// RULE17: All registers reset to zero.
package rxbc_pkg;
  // ----------------------------------------------------------------
  // Register offsets within one port
  // ----------------------------------------------------------------
  localparam logic [7:0]  RXBC_OFS_CTRL_CODE = 8'h15; // Code receiver control
  localparam logic [7:0]  RXBC_OFS_SIG_CTRL  = 8'h13; // Receive signaling control
  localparam logic [7:0]  RXBC_OFS_IDLE_LO   = 8'h20; // Channel 1 idle code
  localparam logic [7:0]  RXBC_OFS_IDLE_T1HI = 8'h37; // Channel 24 idle code
  localparam logic [7:0]  RXBC_OFS_IDLE_HI   = 8'h3f; // Channel 32 idle code
  localparam logic [7:0]  RXBC_OFS_ONES_LO   = 8'h38; // Ones force mask 1
  localparam logic [7:0]  RXBC_OFS_ONES_HI   = 8'h3a; // Ones force mask 3
  localparam logic [7:0]  RXBC_OFS_MW_LO     = 8'h3c; // Milliwatt mask 1
  localparam logic [7:0]  RXBC_OFS_MW_HI     = 8'h3e; // Milliwatt mask 3
  localparam logic [7:0]  RXBC_OFS_SIG_LO    = 8'h40; // Signaling word 1
  localparam logic [7:0]  RXBC_OFS_SIG_HI    = 8'h4f; // Signaling word 16
  localparam logic [7:0]  RXBC_OFS_STATUS    = 8'h16; // Code status (sticky)
  localparam logic [7:0]  RXBC_OFS_INT_CLR   = 8'h17; // Status clear, write only
  localparam logic [7:0]  RXBC_OFS_INT_EN    = 8'h18; // Interrupt enable
  localparam logic [11:0] RXBC_PORT_STRIDE   = 12'h200;
  localparam logic [7:0]  RXBC_RESET_VAL     = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RXBC_BIT_RST    = 7; // Reset request
  localparam int RXBC_BIT_CLR_LO = 4; // Clear filter select
  localparam int RXBC_BIT_VAL_LO = 1; // Valid filter select
  localparam int RXBC_BIT_FORCE  = 4; // Force ones enable in signaling control
  localparam int RXBC_ST_VALID   = 0; // Valid code detected event
  localparam int RXBC_ST_LOST    = 1; // Valid code lost event
  localparam int RXBC_ST_RSTDONE = 2; // Controller reset done event
  localparam logic [7:0]  RXBC_MILLIWATT_CODE = 8'h1e;
  localparam logic [3:0]  RXBC_SIG_ONES       = 4'hf;
  localparam logic [5:0]  RXBC_CODE_IDLE      = 6'h3f;
  // ----------------------------------------------------------------
  // Timing: controller reset finishes below 250 us
  // ----------------------------------------------------------------
  localparam int RXBC_CLK_MHZ      = 125;
  localparam int RXBC_RST_US       = 250;
  localparam int RXBC_RST_CYC_MAX  = RXBC_RST_US * RXBC_CLK_MHZ; // Round down
  localparam int RXBC_RST_CYC_DEF  = 256;
  // Filter tables
  localparam logic [6:0] RXBC_CLR_STEP = 7'd16;
  localparam logic [2:0] RXBC_VAL_N1   = 3'd3;
  localparam logic [2:0] RXBC_VAL_N2   = 3'd5;
  localparam logic [2:0] RXBC_VAL_N3   = 3'd7;

  typedef enum logic [1:0] {
    RXBC_IDLE  = 2'b00,
    RXBC_RESET = 2'b01,
    RXBC_INTEG = 2'b10,
    RXBC_DISIN = 2'b11
  } rxbc_state_t;
endpackage

// >>> rtl/rxbc_top.sv
// Receive code controller, idle codes, per-channel overrides and signaling words for one port.
// Assumes line-side inputs synchronous to i_clk and a one-cycle strobe register port.
`timescale 1ns/1ps
`default_nettype none
module rxbc_top #(
  parameter int RST_CYCLES = rxbc_pkg::RXBC_RST_CYC_DEF, // Controller reset length, < 31250
  parameter int NCH        = 24,                        // T1 channels
  parameter int NIDLE      = 32                         // Idle code registers
) (
  input  wire logic        i_clk,          // 125 MHz clock
  input  wire logic        i_rstn,         // Sync reset, active low
  input  wire logic [11:0] i_addr,         // Byte address including port
  input  wire logic [7:0]  i_wdata,        // Write data
  input  wire logic        i_wr,           // Write strobe
  input  wire logic        i_rd,           // Read strobe
  output logic      [7:0]  o_rdata,        // Read data, cycle after strobe
  output logic             o_irq,          // Level interrupt
  input  wire logic [2:0]  i_port_index,   // This port's index minus one
  input  wire logic        i_e1_mode,      // Port in E1 mode
  input  wire logic        i_code_strobe,  // Code receiver bit time
  input  wire logic        i_code_match,   // Pattern at this bit is a code
  input  wire logic [5:0]  i_code_value,   // Code pattern when matched
  input  wire logic        i_ch_strobe,    // Channel data presented
  input  wire logic [4:0]  i_ch_num,       // Channel number minus one
  input  wire logic [7:0]  i_ch_data,      // Received channel data
  input  wire logic [3:0]  i_ch_sig,       // Received ABCD bits
  input  wire logic        i_ch_sig_upd,   // Signaling bits are new
  input  wire logic        i_out_of_frame_state, // Loss of sync
  output logic      [7:0]  o_rx_serial_data_out, // Data after overrides
  output logic      [3:0]  o_rx_serial_sig,      // Signaling on data path
  output logic      [3:0]  o_rx_signaling_out,   // True signaling
  output logic             o_out_valid,          // Channel output valid
  output logic             o_valid_code,         // Valid code present
  output logic      [5:0]  o_code                // Current valid code
);
  import rxbc_pkg::*;

  typedef struct packed {
    rxbc_state_t      st;
    logic             rst_req;
    logic [1:0]       clr_sel;   // Register copy
    logic [1:0]       val_sel;
    logic [1:0]       clr_act;   // Copies in force
    logic [1:0]       val_act;
    logic [15:0]      rcnt;
    logic [6:0]       bitcnt;
    logic [2:0]       matchcnt;
    logic [5:0]       last_code;
    logic             valid;
    logic [5:0]       code;
    logic [7:0]       sig_ctrl;
    logic [NIDLE-1:0][7:0] idle;
    logic [NCH-1:0]   ones_mask;
    logic [NCH-1:0]   mw_mask;
    logic [NCH-1:0][3:0] sig;
    logic [2:0]       status;
    logic [2:0]       int_en;
    logic [7:0]       rdata;
    logic             irq;
    logic [7:0]       sdata;
    logic [3:0]       ssig;
    logic [3:0]       tsig;
    logic             oval;
  } rxbc_s_t;

  rxbc_s_t s_reg, s_next;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  logic        port_hit;
  logic [7:0]  ofs;
  logic [2:0]  ev;
  logic [2:0]  need_codes;
  logic [6:0]  need_bits;
  assign port_hit = (i_addr[11:9] == i_port_index); // Each port 200h apart [RULE13]
  assign ofs      = i_addr[7:0];

  // Filter tables in force [RULE3] [RULE4]
  always_comb begin
    case (s_reg.val_act)
      2'b00:   need_codes = 3'd1;
      2'b01:   need_codes = RXBC_VAL_N1;
      2'b10:   need_codes = RXBC_VAL_N2;
      default: need_codes = RXBC_VAL_N3;
    endcase
    need_bits = 7'(({5'd0, s_reg.clr_act} + 7'd1) * RXBC_CLR_STEP);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0] idx;
    logic [3:0] rd_a;
    logic [3:0] rd_b;
    idx    = 5'd0;
    rd_a   = 4'd0;
    rd_b   = 4'd0;
    s_next = s_reg;
    ev     = 3'b000;
    s_next.rdata = 8'h00;

    // Code controller; integration and disintegration are exclusive [RULE5]
    case (s_reg.st)
      RXBC_RESET: begin
        s_next.rcnt = s_reg.rcnt + 16'd1;
        if (s_reg.rcnt >= 16'(RST_CYCLES - 1)) begin
          s_next.rst_req = 1'b0;            // Self-clearing [RULE1]
          s_next.clr_act = s_reg.clr_sel;   // New filters applied now [RULE2]
          s_next.val_act = s_reg.val_sel;
          s_next.st      = RXBC_INTEG;
          ev[RXBC_ST_RSTDONE] = 1'b1;
        end
      end
      RXBC_INTEG: begin
        if (i_code_strobe && i_code_match) begin
          if (s_reg.matchcnt != 3'd0 && i_code_value == s_reg.last_code) begin
            s_next.matchcnt = s_reg.matchcnt + 3'd1;
          end else begin
            s_next.matchcnt = 3'd1;
          end
          s_next.last_code = i_code_value;
          if (((s_reg.matchcnt != 3'd0 && i_code_value == s_reg.last_code) ?
               s_reg.matchcnt + 3'd1 : 3'd1) >= need_codes) begin
            s_next.valid  = 1'b1;             // [RULE4]
            s_next.code   = i_code_value;
            s_next.bitcnt = 7'd0;
            s_next.st     = RXBC_DISIN;
            ev[RXBC_ST_VALID] = 1'b1;
          end
        end else if (i_code_strobe) begin
          s_next.matchcnt = 3'd0;
        end
      end
      RXBC_DISIN: begin
        if (i_code_strobe) begin
          if (i_code_match && i_code_value == s_reg.code) begin
            s_next.bitcnt = 7'd0;
          end else if (s_reg.bitcnt + 7'd1 >= need_bits) begin
            s_next.valid    = 1'b0;         // Code gone [RULE3]
            s_next.matchcnt = 3'd0;
            s_next.st       = RXBC_INTEG;
            ev[RXBC_ST_LOST] = 1'b1;
          end else begin
            s_next.bitcnt = s_reg.bitcnt + 7'd1;
          end
        end
      end
      default: s_next.st = RXBC_INTEG;
    endcase

    // ----------------------------------------------------------------
    // Register writes, if and else-if decode
    // ----------------------------------------------------------------
    if (i_wr && port_hit) begin
      if (ofs == RXBC_OFS_CTRL_CODE) begin
        s_next.clr_sel = i_wdata[RXBC_BIT_CLR_LO +: 2];
        s_next.val_sel = i_wdata[RXBC_BIT_VAL_LO +: 2];
        if (i_wdata[RXBC_BIT_RST]) begin
          s_next.rst_req  = 1'b1;           // Host request [RULE1]
          s_next.st       = RXBC_RESET;
          s_next.rcnt     = 16'd0;
          s_next.valid    = 1'b0;           // Clears detect state [RULE16]
          s_next.code     = 6'd0;
          s_next.matchcnt = 3'd0;
          s_next.bitcnt   = 7'd0;
        end
      end else if (ofs == RXBC_OFS_SIG_CTRL) begin
        s_next.sig_ctrl = i_wdata;
      end else if (ofs >= RXBC_OFS_ONES_LO && ofs <= RXBC_OFS_ONES_HI && !i_e1_mode) begin
        s_next.ones_mask[8*(ofs - RXBC_OFS_ONES_LO) +: 8] = i_wdata; // Overlays ch 25-27 in T1 [RULE7] [RULE8]
      end else if (ofs >= RXBC_OFS_MW_LO && ofs <= RXBC_OFS_MW_HI && !i_e1_mode) begin
        s_next.mw_mask[8*(ofs - RXBC_OFS_MW_LO) +: 8] = i_wdata;     // [RULE11]
      end else if (ofs >= RXBC_OFS_IDLE_LO && ofs <= RXBC_OFS_IDLE_HI) begin
        idx = 5'(ofs - RXBC_OFS_IDLE_LO);
        if (ofs <= RXBC_OFS_IDLE_T1HI || i_e1_mode) begin
          s_next.idle[idx] = i_wdata;       // [RULE6] [RULE7]
        end
      end else if (ofs == RXBC_OFS_INT_EN) begin
        s_next.int_en = i_wdata[2:0];
      end
    end

    // Sticky status: set wins over the write-one clear
    if (i_wr && port_hit && ofs == RXBC_OFS_INT_CLR) begin
      s_next.status = s_reg.status & ~i_wdata[2:0];
    end
    s_next.status = s_next.status | ev;
    s_next.irq    = |(s_next.status & s_next.int_en);

    // ----------------------------------------------------------------
    // Reads
    // ----------------------------------------------------------------
    if (i_rd && port_hit) begin
      if (ofs == RXBC_OFS_CTRL_CODE) begin
        s_next.rdata = {s_reg.rst_req, 1'b0, s_reg.clr_sel, 1'b0, s_reg.val_sel, 1'b0}; // [RULE16]
      end else if (ofs == RXBC_OFS_SIG_CTRL) begin
        s_next.rdata = s_reg.sig_ctrl;
      end else if (ofs == RXBC_OFS_STATUS) begin
        s_next.rdata = {s_reg.valid, 4'h0, s_reg.status};
      end else if (ofs == RXBC_OFS_INT_EN) begin
        s_next.rdata = {5'h00, s_reg.int_en};
      end else if (ofs >= RXBC_OFS_ONES_LO && ofs <= RXBC_OFS_ONES_HI && !i_e1_mode) begin
        s_next.rdata = s_reg.ones_mask[8*(ofs - RXBC_OFS_ONES_LO) +: 8];
      end else if (ofs >= RXBC_OFS_MW_LO && ofs <= RXBC_OFS_MW_HI && !i_e1_mode) begin
        s_next.rdata = s_reg.mw_mask[8*(ofs - RXBC_OFS_MW_LO) +: 8];
      end else if (ofs >= RXBC_OFS_IDLE_LO && ofs <= RXBC_OFS_IDLE_HI) begin
        idx = 5'(ofs - RXBC_OFS_IDLE_LO);
        s_next.rdata = s_reg.idle[idx];
      end else if (ofs >= RXBC_OFS_SIG_LO && ofs <= RXBC_OFS_SIG_HI) begin
        idx = 5'(ofs - RXBC_OFS_SIG_LO);
        if (idx < 5'd12) begin                // Channel k high, k+12 low [RULE12]
          rd_a = s_reg.sig[idx];
          rd_b = s_reg.sig[idx + 5'd12];
        end
        s_next.rdata = {rd_a, rd_b};
      end
    end

    // ----------------------------------------------------------------
    // Channel path
    // ----------------------------------------------------------------
    s_next.oval = i_ch_strobe;
    if (i_ch_strobe) begin
      s_next.sdata = i_ch_data;
      s_next.ssig  = i_ch_sig;
      s_next.tsig  = i_ch_sig;                // Always the real bits [RULE9]
      if (!i_e1_mode && i_ch_num < 5'(NCH)) begin
        if (s_reg.mw_mask[i_ch_num]) begin
          s_next.sdata = RXBC_MILLIWATT_CODE; // [RULE11]
        end
        if (s_reg.sig_ctrl[RXBC_BIT_FORCE] && s_reg.ones_mask[i_ch_num]) begin
          s_next.ssig = RXBC_SIG_ONES;        // [RULE8] [RULE10] [RULE14]
        end
      end
      // Frozen while out of frame [RULE15]
      if (i_ch_sig_upd && !i_out_of_frame_state && i_ch_num < 5'(NCH)) begin
        s_next.sig[i_ch_num] = i_ch_sig;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register, all zero after reset except st, which loads RXBC_INTEG
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_reg    <= '0;                         // [RULE17]
      s_reg.st <= RXBC_INTEG;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rdata              = s_reg.rdata;
  assign o_irq                = s_reg.irq;
  assign o_rx_serial_data_out = s_reg.sdata;
  assign o_rx_serial_sig      = s_reg.ssig;
  assign o_rx_signaling_out   = s_reg.tsig;
  assign o_out_valid          = s_reg.oval;
  assign o_valid_code         = s_reg.valid;
  assign o_code               = s_reg.code;
endmodule
`default_nettype wire

// >>> sim/rxbc_props.sv
// Checker for the receive code and channel control block.
// Bound to rxbc_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module rxbc_props #(
  parameter int RST_CYCLES = rxbc_pkg::RXBC_RST_CYC_DEF // Controller reset length
) (
  input wire logic        i_clk,                // Clock
  input wire logic        i_rstn,               // Sync reset
  input wire logic [11:0] i_addr,               // Address
  input wire logic [7:0]  i_wdata,              // Write data
  input wire logic        i_wr,                 // Write strobe
  input wire logic        i_rd,                 // Read strobe
  input wire logic [7:0]  o_rdata,              // Read data
  input wire logic [2:0]  i_port_index,         // Port strap
  input wire logic        i_code_strobe,        // Code bit time
  input wire logic        i_code_match,         // Code seen
  input wire logic        i_ch_strobe,          // Channel strobe
  input wire logic [7:0]  i_ch_data,            // Channel data
  input wire logic [3:0]  i_ch_sig,             // ABCD in
  input wire logic [7:0]  o_rx_serial_data_out, // Data out
  input wire logic [3:0]  o_rx_serial_sig,      // Path signaling
  input wire logic [3:0]  o_rx_signaling_out,   // True signaling
  input wire logic        o_valid_code,         // Code valid
  input wire logic [5:0]  o_code                // Current code
);
  import rxbc_pkg::*;
  // Slack of four cycles covers the write and the done flag
  localparam int RWIN = RST_CYCLES + 4;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  sequence s_ch;
    i_ch_strobe;
  endsequence
  sequence s_rst;
    i_wr && i_addr[11:9] == i_port_index && i_addr[7:0] == RXBC_OFS_CTRL_CODE && i_wdata[7];
  endsequence
  // Codeless bit soon after the code turns valid; nine cycles hold far fewer
  // strobes than the shortest clear count. Writes excluded, a reset may land there
  sequence s_gap;
    o_valid_code && i_code_strobe && !i_code_match && !i_wr;
  endsequence
  port_miss_a: assert property ($past(i_rd) && $past(i_addr[11:9]) != $past(i_port_index) |-> o_rdata == 8'h00)
    else $error("read of another port returned data");
  true_sig_a: assert property (s_ch |=> o_rx_signaling_out == $past(i_ch_sig))
    else $error("signaling output differs from received bits");
  sig_hold_a: assert property (!i_ch_strobe |=> $stable(o_rx_signaling_out))
    else $error("signaling output moved without a strobe");
  mw_data_a: assert property (s_ch |=> o_rx_serial_data_out == $past(i_ch_data)
                              || o_rx_serial_data_out == RXBC_MILLIWATT_CODE)
    else $error("channel data neither passed nor replaced");
  ones_sig_a: assert property (s_ch |=> o_rx_serial_sig == $past(i_ch_sig) || o_rx_serial_sig == RXBC_SIG_ONES)
    else $error("path signaling neither passed nor forced");
  rst_clear_a: assert property (s_rst |-> ##[1:RWIN] !o_valid_code)
    else $error("controller reset left code valid");
  valid_cause_a: assert property ($rose(o_valid_code) |-> $past(i_code_strobe) && $past(i_code_match))
    else $error("code valid without a code bit");
  one_gap_a: assert property ($rose(o_valid_code) ##[0:8] s_gap |=> o_valid_code)
    else $error("one codeless bit cleared the code");
  code_steady_a: assert property (o_valid_code && $past(o_valid_code) |-> $stable(o_code))
    else $error("code changed while valid");
endmodule
bind rxbc_top rxbc_props #(.RST_CYCLES(RST_CYCLES)) props_u (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_port_index(i_port_index), .i_code_strobe(i_code_strobe),
  .i_code_match(i_code_match), .i_ch_strobe(i_ch_strobe), .i_ch_data(i_ch_data), .i_ch_sig(i_ch_sig),
  .o_rx_serial_data_out(o_rx_serial_data_out), .o_rx_serial_sig(o_rx_serial_sig),
  .o_rx_signaling_out(o_rx_signaling_out), .o_valid_code(o_valid_code), .o_code(o_code)
);
`default_nettype wire

// >>> sim/rxbc_line_model.sv
// Model of the framed line feeding channel words and code bits.
// Assumes the bench calls its tasks; one strobe per call.
`timescale 1ns/1ps
`default_nettype none
module rxbc_line_model (
  input  wire logic       i_clk,         // Clock
  output logic            o_ch_strobe,   // Channel strobe
  output logic      [4:0] o_ch_num,      // Channel minus one
  output logic      [7:0] o_ch_data,     // Channel data
  output logic      [3:0] o_ch_sig,      // ABCD bits
  output logic            o_ch_sig_upd,  // New signaling
  output logic            o_oof,         // Loss of sync level
  output logic            o_code_strobe, // Code bit time
  output logic            o_code_match,  // Code seen
  output logic      [5:0] o_code_value   // Code pattern
);
  // Quiet line at time zero
  initial begin
    {o_ch_strobe, o_ch_num, o_ch_data, o_ch_sig, o_ch_sig_upd, o_oof} = '0;
    {o_code_strobe, o_code_match, o_code_value} = '0;
  end
  // Strobes clear and number, data and ABCD invert after the strobe so a stale value never looks valid
  task automatic send_ch(input logic [4:0] n, input logic [7:0] v, input logic [3:0] s, input logic f);
    @(posedge i_clk);
    {o_ch_strobe, o_ch_num, o_ch_data, o_ch_sig, o_ch_sig_upd, o_oof} <= {1'b1, n, v, s, 1'b1, f};
    @(posedge i_clk);
    {o_ch_strobe, o_ch_num, o_ch_data, o_ch_sig, o_ch_sig_upd} <= {1'b0, ~n, ~v, ~s, 1'b0};
  endtask
  // Gap lets the line answer promptly or slowly
  task automatic send_code(input logic m, input logic [5:0] v, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    {o_code_strobe, o_code_match, o_code_value} <= {1'b1, m, v};
    @(posedge i_clk);
    {o_code_strobe, o_code_match, o_code_value} <= {1'b0, ~m, ~v};
  endtask
endmodule
`default_nettype wire

// >>> sim/test_rx_boc_and_channel_control.sv
// Self-checking bench for the receive code and channel control block.
// Assumes the checker is bound in and port index 2 is strapped.
`timescale 1ns/1ps
`default_nettype none
module test_rx_boc_and_channel_control;
  import rxbc_pkg::*;
  localparam logic [11:0] BASE = 12'h400; // Port index 2
  localparam logic [7:0]  RV[8] = '{8'h15, 8'h13, 8'h20, 8'h38, 8'h3c, 8'h40, 8'h16, 8'h18};
  logic        i_clk, i_rstn, i_wr, i_rd, i_e1_mode, o_irq, o_out_valid, o_valid_code, f;
  logic [11:0] i_addr;
  logic [7:0]  i_wdata, o_rdata, o_rx_serial_data_out, d;
  logic [3:0]  o_rx_serial_sig, o_rx_signaling_out, sg[0:24];
  logic [5:0]  o_code;
  logic [1:0]  sel;
  logic [23:0] om, mm;
  logic [31:0] lfsr;
  wire         cs, cm, hs, hu, out_of_frame_state;
  wire  [5:0]  cv;
  wire  [4:0]  hn;
  wire  [7:0]  hd;
  wire  [3:0]  hg;
  int          errors, n_tests, t;
  rxbc_line_model line_u (.i_clk(i_clk), .o_ch_strobe(hs), .o_ch_num(hn), .o_ch_data(hd), .o_ch_sig(hg),
    .o_ch_sig_upd(hu), .o_oof(out_of_frame_state), .o_code_strobe(cs), .o_code_match(cm), .o_code_value(cv));
  // Short controller reset keeps the run brief
  rxbc_top #(.RST_CYCLES(8)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_port_index(3'd2), .i_e1_mode(i_e1_mode),
    .i_code_strobe(cs), .i_code_match(cm), .i_code_value(cv), .i_ch_strobe(hs), .i_ch_num(hn),
    .i_ch_data(hd), .i_ch_sig(hg), .i_ch_sig_upd(hu), .i_out_of_frame_state(out_of_frame_state),
    .o_rx_serial_data_out(o_rx_serial_data_out), .o_rx_serial_sig(o_rx_serial_sig),
    .o_rx_signaling_out(o_rx_signaling_out), .o_out_valid(o_out_valid), .o_valid_code(o_valid_code),
    .o_code(o_code));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lf(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int fn(input int s);
    return s == 0 ? 1 : 2 * s + 1;
  endfunction
  function automatic int ln(input int s);
    return 16 * (s + 1);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wra(input logic [11:0] a, input logic [7:0] v);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] v);
    wra(BASE | {4'h0, o}, v);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rda(input logic [11:0] a, output logic [7:0] v);
    @(posedge i_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask
  task automatic rd(input logic [7:0] o, output logic [7:0] v);
    rda(BASE | {4'h0, o}, v);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // Hang guard
  initial begin
    repeat (50000) @(posedge i_clk);
    errors++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_rstn, i_wr, i_rd, i_addr, i_wdata, i_e1_mode, errors, n_tests} = '0;
    lfsr = 32'h5ef5;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      rd(RV[k], d);
      chk(d, RXBC_RESET_VAL);
    end
    $display("test reset values done");
    wr(RXBC_OFS_IDLE_LO, 8'ha5);
    wr(RXBC_OFS_IDLE_T1HI, 8'h5a);
    wra(12'h020, 8'h33);
    rd(RXBC_OFS_IDLE_LO, d);
    chk(d, 8'ha5);
    rd(RXBC_OFS_IDLE_T1HI, d);
    chk(d, 8'h5a);
    rda(12'h020, d);
    chk(d, 8'h00);
    wr(RXBC_OFS_IDLE_HI, 8'h99);
    i_e1_mode <= 1'b1;
    rd(RXBC_OFS_IDLE_HI, d);
    chk(d, 8'h00);
    wr(RXBC_OFS_IDLE_HI, 8'h3c);
    rd(RXBC_OFS_IDLE_HI, d);
    chk(d, 8'h3c);
    i_e1_mode <= 1'b0;
    $display("test idle codes done");
    repeat (8) lfsr = lf(lfsr);
    om = lfsr[23:0];
    repeat (24) lfsr = lf(lfsr);
    mm = lfsr[23:0];
    for (int j = 0; j < 3; j++) begin
      wr(RXBC_OFS_ONES_LO + j[7:0], om[8*j +: 8]);
      wr(RXBC_OFS_MW_LO + j[7:0], mm[8*j +: 8]);
    end
    // Every channel once, force bit toggled at random
    for (int i = 0; i < 24; i++) begin
      repeat (8) lfsr = lf(lfsr);
      f = lfsr[9];
      sg[i] = lfsr[3:0];
      wr(RXBC_OFS_SIG_CTRL, {3'b000, f, 4'h0});
      line_u.send_ch(i[4:0], lfsr[17:10], sg[i], 1'b0);
      #1;
      chk(o_rx_serial_data_out, mm[i] ? RXBC_MILLIWATT_CODE : lfsr[17:10]);
      chk({4'h0, o_rx_serial_sig}, {4'h0, (f && om[i]) ? RXBC_SIG_ONES : sg[i]});
      chk({4'h0, o_rx_signaling_out}, {4'h0, sg[i]});
      chk({7'h0, o_out_valid}, 8'h01);
    end
    for (int k = 0; k < 13; k++) begin
      rd(RXBC_OFS_SIG_LO + k[7:0], d);
      chk(d, k < 12 ? {sg[k], sg[k + 12]} : 8'h00);
    end
    line_u.send_ch(5'd0, 8'h00, ~sg[0], 1'b1);
    rd(RXBC_OFS_SIG_LO, d);
    chk(d, {sg[0], sg[12]});
    // Mask writes in E1 land on an idle code, the T1 mask keeps its value
    i_e1_mode <= 1'b1;
    wr(RXBC_OFS_MW_LO, ~mm[7:0]);
    i_e1_mode <= 1'b0;
    rd(RXBC_OFS_MW_LO, d);
    chk(d, mm[7:0]);
    $display("test channel overrides done");
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      wr(RXBC_OFS_CTRL_CODE, {2'b10, sel, 1'b0, sel, 1'b0});
      rd(RXBC_OFS_CTRL_CODE, d);
      chk({7'h0, d[7]}, 8'h01);
      for (t = 0; t < 20 && d[7] !== 1'b0; t++) rd(RXBC_OFS_CTRL_CODE, d);
      if (d[7] !== 1'b0) begin
        errors++;
        stop_test();
      end
      chk(d, {2'b00, sel, 1'b0, sel, 1'b0});
      // Unapplied selections must not reach the filters
      wr(RXBC_OFS_CTRL_CODE, {2'b00, ~sel, 1'b0, ~sel, 1'b0});
      for (int j = 1; j <= fn(s); j++) begin
        line_u.send_code(1'b1, 6'h2a, int'(lfsr[1:0]));
        #1;
        chk({7'h0, o_valid_code}, {7'h0, j == fn(s)});
      end
      chk({2'b00, o_code}, 8'h2a);
      for (int j = 1; j <= ln(s); j++) begin
        lfsr = lf(lfsr);
        line_u.send_code(1'b0, lfsr[5:0], 0);
        #1;
        chk({7'h0, o_valid_code}, {7'h0, j < ln(s)});
      end
    end
    $display("test code filters done");
    rd(RXBC_OFS_STATUS, d);
    chk(d & 8'h07, 8'h07);
    chk({7'h0, o_irq}, 8'h00);
    wr(RXBC_OFS_INT_EN, 8'h04);
    @(posedge i_clk);
    #1;
    chk({7'h0, o_irq}, 8'h01);
    wr(RXBC_OFS_INT_CLR, 8'h04);
    @(posedge i_clk);
    #1;
    chk({7'h0, o_irq}, 8'h00);
    rd(RXBC_OFS_STATUS, d);
    chk(d & 8'h07, 8'h03);
    $display("test interrupt done");
    stop_test();
  end
endmodule
`default_nettype wire
